// >>> rtl/acfg_pkg.sv
// Purpose: Constants and types for the input configuration and sequence block
// Assumes: 16-bit serial words, MSB first, captured on rising serial clock
// Notes: Mode-control field layout and mode codes are local choices
package acfg_pkg;
   localparam int WORD_BITS = 16;
   localparam int NIB_BITS = 4;
   localparam int SEQ_DEPTH = 256;
   localparam int SEL_HI = 15;
   localparam int SEL_LO = 11;
   localparam int FLD_HI = 10;
   localparam int FLD_LO = 3;
   localparam int COM_BIT = 2;
   localparam int MODE_HI = 14;
   localparam int MODE_LO = 11;
   localparam int CHAN_HI = 10;
   localparam int CHAN_LO = 7;
   localparam logic [4:0] PSEUDO_DIFF_SELECT_CODE = 5'h11;
   localparam logic [4:0] BIPOLAR_SELECT_CODE = 5'h12;
   localparam logic [4:0] SCAN_HIGH_SELECT_CODE = 5'h14;
   localparam logic [4:0] SCAN_LOW_SELECT_CODE = 5'h15;
   localparam logic [4:0] SEQUENCE_SELECT_CODE = 5'h16;
   localparam logic [4:0] LAST_BIT = 5'h0F;
   localparam logic [7:0] PAIR_CFG_RESET = 8'h00;
   localparam logic [15:0] SCAN_MASK_RESET = 16'h0000;
   localparam logic [7:0] SEQ_LEN_RESET = 8'h00;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [3:0] COMMON_INPUT_CHANNEL = 4'hF;
   localparam logic [3:0] MODE_IDLE = 4'h0;
   localparam logic [3:0] MODE_MANUAL = 4'h1;
   localparam logic [3:0] MODE_REPEAT = 4'h2;
   localparam logic [3:0] MODE_ASCENDING_INT = 4'h3;
   localparam logic [3:0] ASCENDING_SCAN_EXTERNAL_CLOCK = 4'h4;
   localparam logic [3:0] MODE_UPPER_INT = 4'h5;
   localparam logic [3:0] UPPER_RANGE_SCAN_EXTERNAL_CLOCK = 4'h6;
   localparam logic [3:0] MODE_MASKED_INT = 4'h7;
   localparam logic [3:0] MASKED_SCAN_EXTERNAL_CLOCK = 4'h8;
   localparam logic [3:0] MODE_SEQUENCE = 4'h9;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ARM = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_DRAIN = 4'b1000
   } acfg_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } acfg_pins_t;

   typedef struct packed {
      logic common_ref;
      logic pair;
      logic twos;
   } acfg_coding_t;
endpackage

// >>> rtl/acfg_top.sv
// Purpose: Input-type registers, coding resolution and channel sequence load
// Assumes: Serial pins are asynchronous to clk_sys; chip select and clock pass three flip-flops, data two
// Notes: Sequence entry read has two cycles of latency
`timescale 1ns/100ps
module acfg_top (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire acfg_pkg::acfg_pins_t pins,
   input wire logic [3:0] conv_ch,
   input wire logic [7:0] seq_idx,
   output logic [3:0] scan_mode,
   output logic [3:0] single_channel_field,
   output logic [15:0] custom_scan_mask,
   output logic use_scan_mask,
   output logic [7:0] sequence_length_minus_one,
   output logic seq_valid,
   output logic [3:0] seq_entry,
   output acfg_pkg::acfg_coding_t coding
);
   import acfg_pkg::*;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic sck_s1;
      logic sck_s2;
      logic sck_s3;
      logic din_s1;
      logic din_s2;
      logic [15:0] shift;
      logic [4:0] bcnt;
      logic [7:0] pair_pseudo_diff_bit;
      logic [7:0] pair_bipolar_bit;
      logic common_reference_mode;
      logic [3:0] mode;
      logic [3:0] chan;
      logic [15:0] mask;
      logic use_mask;
      logic [7:0] seq_len;
      logic [8:0] wr_idx;
      logic [8:0] loaded;
      logic seq_valid;
      logic seq_hit;
      logic [3:0] seq_entry;
      acfg_coding_t coding;
      acfg_state_t st;
   } acfg_regs_t;

   localparam acfg_regs_t REGS_RESET = '{
      cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
      sck_s1: 1'b0, sck_s2: 1'b0, sck_s3: 1'b0,
      din_s1: 1'b0, din_s2: 1'b0,
      shift: 16'h0000, bcnt: 5'h00,
      pair_pseudo_diff_bit: PAIR_CFG_RESET,
      pair_bipolar_bit: PAIR_CFG_RESET,
      common_reference_mode: 1'b0,
      mode: MODE_IDLE, chan: CHAN_RESET, mask: SCAN_MASK_RESET,
      use_mask: 1'b0, seq_len: SEQ_LEN_RESET,
      wr_idx: 9'h000, loaded: 9'h000, seq_valid: 1'b0,
      seq_hit: 1'b0, seq_entry: 4'h0,
      coding: '{common_ref: 1'b0, pair: 1'b0, twos: 1'b0},
      st: ST_IDLE
   };

   acfg_regs_t r_reg;
   acfg_regs_t r_next;
   logic [3:0] seq_mem [SEQ_DEPTH];
   logic [3:0] seq_raw;
   logic mem_we;
   logic [7:0] mem_wa;
   logic [3:0] mem_wd;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic word_done;
   logic [15:0] word;

   ////////////////////////////////////////////////////////////////////////
   // Pair bit of a channel: pair 0/1 sits in the top field bit
   function automatic logic pair_bit(input logic [7:0] v,
                                     input logic [3:0] ch);
      pair_bit = v[3'd7 - ch[3:1]];
   endfunction

   // Coding of one channel from the pair registers
   function automatic acfg_coding_t resolve(input logic [7:0] pd,
                                            input logic [7:0] bp,
                                            input logic com,
                                            input logic [3:0] ch);
      resolve = '{common_ref: 1'b0, pair: 1'b0, twos: 1'b0};
      if (com) begin
         resolve.common_ref = 1'b1;
      end else if (pair_bit(pd, ch)) begin
         resolve.pair = 1'b1;
      end else if (pair_bit(bp, ch)) begin
         resolve.pair = 1'b1;
         resolve.twos = 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on the second and third stages only
   assign cs_fall = r_reg.cs_s3 & ~r_reg.cs_s2;
   assign cs_rise = ~r_reg.cs_s3 & r_reg.cs_s2;
   assign sck_rise = ~r_reg.sck_s3 & r_reg.sck_s2 & ~r_reg.cs_s2;
   assign word = {r_reg.shift[14:0], r_reg.din_s2};
   assign word_done = sck_rise && !cs_fall && (r_reg.st != ST_LOAD)
                      && (r_reg.st != ST_DRAIN) && (r_reg.bcnt == LAST_BIT);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      r_next = r_reg;
      mem_we = 1'b0;
      mem_wa = 8'h00;
      mem_wd = 4'h0;
      r_next.cs_s1 = pins.cs_n;
      r_next.cs_s2 = r_reg.cs_s1;
      r_next.cs_s3 = r_reg.cs_s2;
      r_next.sck_s1 = pins.sclk;
      r_next.sck_s2 = r_reg.sck_s1;
      r_next.sck_s3 = r_reg.sck_s2;
      r_next.din_s1 = pins.din;
      r_next.din_s2 = r_reg.din_s1;
      if (cs_fall) begin
         r_next.bcnt = 5'h00;
         r_next.shift = 16'h0000;
         if (r_reg.st == ST_ARM) begin
            r_next.st = ST_LOAD;
            r_next.wr_idx = 9'h000;
            r_next.seq_valid = 1'b0;
         end
      end else if (sck_rise) begin
         case (r_reg.st)
            ST_LOAD: begin
               r_next.shift = {r_reg.shift[14:0], r_reg.din_s2};
               r_next.bcnt = r_reg.bcnt + 5'h01;
               if (r_reg.bcnt[1:0] == 2'b11) begin
                  mem_we = 1'b1;
                  mem_wa = r_reg.wr_idx[7:0];
                  mem_wd = {r_reg.shift[2:0], r_reg.din_s2};
                  r_next.wr_idx = r_reg.wr_idx + 9'h001;
                  if (r_reg.wr_idx == {1'b0, r_reg.seq_len}) begin
                     r_next.st = ST_DRAIN;
                  end
               end
            end
            ST_DRAIN: begin
               r_next.bcnt = r_reg.bcnt;
            end
            default: begin
               if (r_reg.bcnt < 5'h10) begin
                  r_next.shift = word;
                  r_next.bcnt = r_reg.bcnt + 5'h01;
               end
               if (word_done) begin
                  if (word[SEL_HI]) begin
                     case (word[SEL_HI:SEL_LO])
                        PSEUDO_DIFF_SELECT_CODE: begin
                           r_next.pair_pseudo_diff_bit =
                              word[FLD_HI:FLD_LO];
                           r_next.common_reference_mode =
                              word[COM_BIT];
                        end
                        BIPOLAR_SELECT_CODE: begin
                           r_next.pair_bipolar_bit =
                              word[FLD_HI:FLD_LO];
                        end
                        SCAN_HIGH_SELECT_CODE: begin
                           r_next.mask[15:8] = word[FLD_HI:FLD_LO];
                        end
                        SCAN_LOW_SELECT_CODE: begin
                           r_next.mask[7:0] = word[FLD_HI:FLD_LO];
                        end
                        SEQUENCE_SELECT_CODE: begin
                           r_next.seq_len = word[FLD_HI:FLD_LO];
                           r_next.st = ST_ARM;
                        end
                        default: begin
                           r_next.st = r_reg.st;
                        end
                     endcase
                  end else begin
                     r_next.mode = word[MODE_HI:MODE_LO];
                     r_next.chan = word[CHAN_HI:CHAN_LO];
                  end
               end
            end
         endcase
      end else if (cs_rise) begin
         if (r_reg.st == ST_LOAD || r_reg.st == ST_DRAIN) begin
            r_next.st = ST_IDLE;
            r_next.loaded = r_reg.wr_idx;
            r_next.seq_valid = 1'b1;
         end
      end
      r_next.use_mask = (r_reg.mode == MODE_MASKED_INT)
                        || (r_reg.mode == MASKED_SCAN_EXTERNAL_CLOCK);
      r_next.seq_hit = r_reg.seq_valid
                       && ({1'b0, seq_idx} < r_reg.loaded);
      r_next.seq_entry = r_reg.seq_hit ? seq_raw : 4'h0;
      r_next.coding = resolve(r_reg.pair_pseudo_diff_bit,
                              r_reg.pair_bipolar_bit,
                              r_reg.common_reference_mode,
                              conv_ch);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r_reg <= REGS_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequence pattern store
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         seq_mem[mem_wa] <= mem_wd;
      end
      seq_raw <= seq_mem[seq_idx];
   end

   ////////////////////////////////////////////////////////////////////////
   assign scan_mode = r_reg.mode;
   assign single_channel_field = r_reg.chan;
   assign custom_scan_mask = r_reg.mask;
   assign use_scan_mask = r_reg.use_mask;
   assign sequence_length_minus_one = r_reg.seq_len;
   assign seq_valid = r_reg.seq_valid;
   assign seq_entry = r_reg.seq_entry;
   assign coding = r_reg.coding;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   sequence pattern_frame_end;
      (r_reg.st == ST_LOAD || r_reg.st == ST_DRAIN) && cs_rise;
   endsequence

   sequence idx_beyond_load;
      r_reg.seq_valid && ({1'b0, seq_idx} >= r_reg.loaded)
      && (r_reg.st == ST_IDLE) && !cs_fall;
   endsequence

   pdiff_reg_write_a: assert property (
      word_done && word[15:11] == PSEUDO_DIFF_SELECT_CODE |=>
      r_reg.pair_pseudo_diff_bit == $past(word[10:3])
      && r_reg.common_reference_mode == $past(word[2]))
      else $error("pseudo-differential register not written");

   bip_reg_write_a: assert property (
      word_done && word[15:11] == BIPOLAR_SELECT_CODE |=>
      r_reg.pair_bipolar_bit == $past(word[10:3])
      && $stable(r_reg.pair_pseudo_diff_bit))
      else $error("bipolar register not written");

   mode_word_a: assert property (
      word_done && !word[15] |=>
      r_reg.mode == $past(word[14:11])
      && $stable(r_reg.pair_bipolar_bit) && $stable(r_reg.mask))
      else $error("mode control word misdecoded");

   common_ref_a: assert property (
      r_reg.common_reference_mode |=>
      coding.common_ref && !coding.pair && !coding.twos)
      else $error("common reference coding wrong");

   pdiff_wins_a: assert property (
      !r_reg.common_reference_mode
      && pair_bit(r_reg.pair_pseudo_diff_bit, conv_ch)
      && pair_bit(r_reg.pair_bipolar_bit, conv_ch) |=>
      coding.pair && !coding.twos && !coding.common_ref)
      else $error("pseudo-differential precedence lost");

   bipolar_pair_a: assert property (
      !r_reg.common_reference_mode
      && !pair_bit(r_reg.pair_pseudo_diff_bit, conv_ch)
      && pair_bit(r_reg.pair_bipolar_bit, conv_ch) |=>
      coding.pair && coding.twos)
      else $error("bipolar pair coding wrong");

   single_ended_a: assert property (
      !r_reg.common_reference_mode
      && !pair_bit(r_reg.pair_pseudo_diff_bit, conv_ch)
      && !pair_bit(r_reg.pair_bipolar_bit, conv_ch) |=>
      !coding.pair && !coding.twos && !coding.common_ref)
      else $error("single-ended coding wrong");

   seq_activate_a: assert property (
      pattern_frame_end |=> r_reg.seq_valid && r_reg.st == ST_IDLE)
      else $error("sequence not activated at frame end");

   excess_drop_a: assert property (
      r_reg.st == ST_DRAIN |-> !mem_we)
      else $error("excess nibble written");

   length_stop_a: assert property (
      mem_we && r_reg.wr_idx == {1'b0, r_reg.seq_len} |=>
      r_reg.st == ST_DRAIN)
      else $error("sequence length not honoured");

   short_fill_a: assert property (
      idx_beyond_load ##1 idx_beyond_load |=> seq_entry == 4'h0)
      else $error("missing entry not input 0");

   mask_select_a: assert property (
      r_reg.mode == MASKED_SCAN_EXTERNAL_CLOCK |=> use_scan_mask)
      else $error("masked scan does not use mask");

   pattern_arm_a: assert property (
      r_reg.st == ST_ARM && cs_fall |=>
      r_reg.st == ST_LOAD && !r_reg.seq_valid && r_reg.wr_idx == 9'h000)
      else $error("pattern frame not started after length frame");

   partial_drop_a: assert property (
      pattern_frame_end |=> r_reg.loaded == $past(r_reg.wr_idx))
      else $error("entry count wrong at frame end");
endmodule

// >>> sim/acfg_host_model.sv
// Purpose: Serial host model driving chip select, clock and data
// Assumes: Moves pins at clk_sys falling edges, 8 clocks per serial bit
// Notes: Serial clock stands low between frames, data inverts on release
`timescale 1ns/100ps
module acfg_host_model (
   input wire logic clk_sys,
   output acfg_pkg::acfg_pins_t pins
);
   import acfg_pkg::*;
   initial begin
      pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Sends d[n-1:0] MSB first in one chip-select frame
   task automatic frame(input logic [31:0] d, input int n);
      pins.cs_n = 1'b0;
      wt(4);
      for (int i = n - 1; i >= 0; i--) begin
         pins.din = d[i];
         wt(4);
         pins.sclk = 1'b1;
         wt(4);
         pins.sclk = 1'b0;
      end
      wt(4);
      pins.cs_n = 1'b1;
      pins.din = ~pins.din;
      wt(8);
   endtask
endmodule

// >>> sim/acfg_top_tb.sv
// Purpose: Self-checking bench for the configuration and sequence block
// Assumes: Host model frames all serial traffic
// Notes: Coding read two cycles after channel, entry three cycles after index
`timescale 1ns/100ps
module acfg_top_tb;
   import acfg_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   acfg_pins_t pins;
   logic [3:0] conv_ch = 4'h0;
   logic [7:0] seq_idx = 8'h00;
   logic [3:0] scan_mode;
   logic [3:0] single_channel_field;
   logic [15:0] custom_scan_mask;
   logic use_scan_mask;
   logic [7:0] sequence_length_minus_one;
   logic seq_valid;
   logic [3:0] seq_entry;
   acfg_coding_t coding;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] pd_b = 8'h60;
   logic [7:0] bp_b = 8'hC0;
   logic [23:0] tbl;

   always #12.5 clk_sys = ~clk_sys;

   acfg_host_model acfg_host_model_inst (.clk_sys(clk_sys), .pins(pins));

   acfg_top acfg_top_inst (
      .clk_sys(clk_sys), .rstn(rstn), .pins(pins), .conv_ch(conv_ch),
      .seq_idx(seq_idx), .scan_mode(scan_mode),
      .single_channel_field(single_channel_field),
      .custom_scan_mask(custom_scan_mask), .use_scan_mask(use_scan_mask),
      .sequence_length_minus_one(sequence_length_minus_one),
      .seq_valid(seq_valid), .seq_entry(seq_entry), .coding(coding)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("Counts: %0d compares, %0d errors", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] d);
      acfg_host_model_inst.frame({16'h0000, d}, 16);
   endtask

   task automatic rd_code(input logic [3:0] ch, input logic [2:0] exp);
      conv_ch = ch;
      repeat (2) @(negedge clk_sys);
      check({13'h0000, coding}, {13'h0000, exp});
   endtask

   task automatic rd_seq(input logic [7:0] idx, input logic [3:0] exp);
      seq_idx = idx;
      repeat (3) @(negedge clk_sys);
      check({12'h000, seq_entry}, {12'h000, exp});
   endtask

   function automatic logic [2:0] exp_code(input logic [3:0] ch);
      logic p;
      logic b;
      p = pd_b[3'd7 - ch[3:1]];
      b = bp_b[3'd7 - ch[3:1]];
      return {1'b0, p | b, b & ~p};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (4) @(negedge clk_sys);
      check({12'h000, scan_mode}, 16'h0000);
      check({8'h00, sequence_length_minus_one}, 16'h0000);
      check({15'h0000, seq_valid}, 16'h0000);
      check(custom_scan_mask, 16'h0000);
      rd_seq(8'h00, 4'h0);
      for (int c = 0; c < 16; c++) rd_code(4'(c), 3'b000);
      $display("Test reset values done");
      wr({PSEUDO_DIFF_SELECT_CODE, pd_b, 3'b011});
      wr({BIPOLAR_SELECT_CODE, bp_b, 3'b111});
      for (int c = 0; c < 16; c++) rd_code(4'(c), exp_code(4'(c)));
      wr({PSEUDO_DIFF_SELECT_CODE, pd_b, 3'b100});
      for (int c = 0; c < 16; c++) rd_code(4'(c), 3'b100);
      $display("Test pair coding done");
      for (int m = 1; m < 10; m++) begin
         wr({1'b0, 4'(m), 4'(15 - m), 7'h00});
         check({12'h000, scan_mode}, {12'h000, 4'(m)});
         check({12'h000, single_channel_field}, {12'h000, 4'(15 - m)});
         check({15'h0000, use_scan_mask}, {15'h0000, m == 7 || m == 8});
      end
      wr({SCAN_HIGH_SELECT_CODE, 8'hA5, 3'b000});
      wr({SCAN_LOW_SELECT_CODE, 8'h3C, 3'b000});
      check(custom_scan_mask, 16'hA53C);
      check({12'h000, scan_mode}, 16'h0009);
      $display("Test scan modes done");
      wr({SEQUENCE_SELECT_CODE, 8'h04, 3'b000});
      acfg_host_model_inst.frame(32'h00003CEA, 14);
      check({15'h0000, seq_valid}, 16'h0001);
      check({8'h00, sequence_length_minus_one}, 16'h0004);
      tbl = 24'hF3A000;
      for (int i = 0; i < 6; i++) rd_seq(8'(i), tbl[23 - 4 * i -: 4]);
      wr({SEQUENCE_SELECT_CODE, 8'h01, 3'b000});
      acfg_host_model_inst.frame(32'h00005678, 16);
      tbl = 24'h560000;
      for (int i = 0; i < 4; i++) rd_seq(8'(i), tbl[23 - 4 * i -: 4]);
      $display("Test sequence load done");
      stop_test();
   end
endmodule
